/* File: inc/ccr_pkg.sv */
// constants for the core clock ratio and reset front end
// assumes one 200 MHz clock drives every flop of the block
package ccr_pkg;
  localparam int CLK_PERIOD_NS = 5;
  // least delay from captured strap to the reset-done output
  localparam int RST_DONE_NS = 100;
  localparam int RST_DONE_CYC =
    (RST_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] RST_DONE_CNT = RST_DONE_CYC[CNT_W-1:0];
  // ratio strap encodings
  localparam int STRAP_W = 3;
  localparam logic [STRAP_W-1:0] STRAP_R4 = 3'h0;
  localparam logic [STRAP_W-1:0] STRAP_R5 = 3'h1;
  localparam logic [STRAP_W-1:0] STRAP_R6 = 3'h2;
  localparam logic [STRAP_W-1:0] STRAP_R7 = 3'h3;
  localparam logic [STRAP_W-1:0] STRAP_R8 = 3'h4;
  localparam logic [STRAP_W-1:0] STRAP_R10 = 3'h5;
  localparam logic [STRAP_W-1:0] STRAP_R12 = 3'h6;
  localparam logic [STRAP_W-1:0] STRAP_RSVD = 3'h7;
  // ratio values and their reset value
  localparam int RATIO_W = 4;
  localparam logic [RATIO_W-1:0] RATIO_4 = 4'h4;
  localparam logic [RATIO_W-1:0] RATIO_5 = 4'h5;
  localparam logic [RATIO_W-1:0] RATIO_6 = 4'h6;
  localparam logic [RATIO_W-1:0] RATIO_7 = 4'h7;
  localparam logic [RATIO_W-1:0] RATIO_8 = 4'h8;
  localparam logic [RATIO_W-1:0] RATIO_10 = 4'hA;
  localparam logic [RATIO_W-1:0] RATIO_12 = 4'hC;
  localparam logic [RATIO_W-1:0] RATIO_RST = RATIO_4;
  // half-period counter, two toggles per core clock period
  localparam int HALF_W = 5;
  localparam logic [HALF_W-1:0] HALF_ZERO = 5'h00;
  // synchroniser bit positions
  localparam int SYN_W = 5;
  localparam int SYN_STRAP_LO = 0;
  localparam int SYN_SCLK = 3;
  localparam int SYN_POR = 4;
  typedef enum logic [1:0] {
    CCR_RESET,
    CCR_CAPTURE,
    CCR_WAIT,
    CCR_RUN
  } ccr_state_t;
endpackage

/* File: src/ccr_sync.sv */
// two-flop synchroniser for a group of unrelated level inputs
// assumes each bit is an independent level from outside the clock
`timescale 1ns/1ps
module ccr_sync
#(
  parameter int W = 1
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage is read only by the second stage
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* File: src/ccr_top.sv */
// core clock ratio, reset sequencing and reset-time pin release
// assumes the board holds the strap steady outside reset and loops
// reset_done back into dram_por_in externally
`timescale 1ns/1ps
// Function
// - core clock gives n pulses per system clock, n decoded from strap
// - reset forces known state and holds the program sequencer idle
// - reset_done output rises once the internal reset sequence ends
// - the core_clock and reset_done pins are released to high impedance during reset
// - asynchronous reset, strap, clock and por inputs are synchronised
module ccr_top
  import ccr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [STRAP_W-1:0] core_ratio_strap,
  input wire logic sys_clock_pin,
  input wire logic dram_por_in_n,
  output logic core_clock,
  output logic core_clock_oe,
  output logic reset_done,
  output logic reset_done_oe,
  output logic seq_idle,
  output logic dram_init,
  output logic [RATIO_W-1:0] core_ratio,
  output logic ratio_reserved
);
  logic [1:0] rst_chain_r;
  logic rst_q_n;
  logic [SYN_W-1:0] syn_q;
  logic [STRAP_W-1:0] strap_q;
  logic sclk_prev_r;
  logic sclk_rise;
  ccr_state_t state_r;
  logic [CNT_W-1:0] done_cnt_r;
  logic [HALF_W-1:0] half_r;
  logic [RATIO_W-1:0] ratio_nxt;

  // reset synchroniser
  // assertion acts at the next clock edge, release takes two edges to settle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rst_chain_r <= 2'h0;
    else
      rst_chain_r <= {rst_chain_r[0], 1'b1};
  end
  assign rst_q_n = rst_chain_r[1];

  ccr_sync #(.W(SYN_W)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({dram_por_in_n, sys_clock_pin, core_ratio_strap}),
    .q(syn_q)
  );

  // synchronised strap, named so the checks can read it
  assign strap_q = syn_q[SYN_STRAP_LO +: STRAP_W];

  // system clock edge detect works on the synchronised copy only
  always_ff @(posedge clock)
  begin
    if (!rst_q_n)
      sclk_prev_r <= 1'b0;
    else
      sclk_prev_r <= syn_q[SYN_SCLK];
  end
  assign sclk_rise = syn_q[SYN_SCLK] & ~sclk_prev_r;

  // strap decode
  // reserved code falls back to the default ratio and is flagged
  always_comb
  begin
    case (syn_q[SYN_STRAP_LO +: STRAP_W])
      STRAP_R4: ratio_nxt = RATIO_4;
      STRAP_R5: ratio_nxt = RATIO_5;
      STRAP_R6: ratio_nxt = RATIO_6;
      STRAP_R7: ratio_nxt = RATIO_7;
      STRAP_R8: ratio_nxt = RATIO_8;
      STRAP_R10: ratio_nxt = RATIO_10;
      STRAP_R12: ratio_nxt = RATIO_12;
      default: ratio_nxt = RATIO_RST;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_q_n)
      state_r <= CCR_RESET;
    else
    begin
      case (state_r)
        CCR_RESET: state_r <= CCR_CAPTURE;
        CCR_CAPTURE: state_r <= CCR_WAIT;
        CCR_WAIT:
        begin
          if (done_cnt_r == '0)
            state_r <= CCR_RUN;
        end
        CCR_RUN: state_r <= CCR_RUN;
        default: state_r <= CCR_RESET;
      endcase
    end
  end

  // reset-done delay counter
  always_ff @(posedge clock)
  begin
    if (!rst_q_n)
      done_cnt_r <= RST_DONE_CNT;
    else if (state_r == CCR_WAIT && done_cnt_r != '0)
      done_cnt_r <= done_cnt_r - 1'b1;
  end

  // strap capture once per reset
  // strap synchroniser has settled by the time capture comes round
  always_ff @(posedge clock)
  begin
    if (!rst_q_n)
    begin
      core_ratio <= RATIO_RST;
      ratio_reserved <= 1'b0;
    end
    else if (state_r == CCR_CAPTURE)
    begin
      core_ratio <= ratio_nxt;
      ratio_reserved <=
        (syn_q[SYN_STRAP_LO +: STRAP_W] == STRAP_RSVD);
    end
  end

  // core clock generation
  // each system clock rise reloads 2n half periods; the system period must
  // span at least 2n clocks or the burst is cut short by the reload
  always_ff @(posedge clock)
  begin
    if (!rst_q_n || state_r != CCR_RUN)
    begin
      half_r <= HALF_ZERO;
      core_clock <= 1'b0;
    end
    else if (sclk_rise)
    begin
      half_r <= HALF_W'({core_ratio, 1'b0});
      core_clock <= 1'b0;
    end
    else if (half_r != HALF_ZERO)
    begin
      half_r <= half_r - 1'b1;
      core_clock <= ~core_clock;
    end
  end

  // reset done and dram release
  // dram init waits for the looped-back por input, not reset_done itself
  always_ff @(posedge clock)
  begin
    if (!rst_q_n)
    begin
      reset_done <= 1'b0;
      dram_init <= 1'b0;
    end
    else
    begin
      reset_done <= (state_r == CCR_RUN);
      dram_init <= syn_q[SYN_POR];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_q_n)
    begin
      core_clock_oe <= 1'b0;
      reset_done_oe <= 1'b0;
    end
    else
    begin
      core_clock_oe <= (state_r == CCR_RUN);
      reset_done_oe <= 1'b1;
    end
  end

  // sequencer idle until dram is released
  always_ff @(posedge clock)
  begin
    if (!rst_q_n)
      seq_idle <= 1'b1;
    else
      seq_idle <= ~(reset_done & dram_init);
  end

  // checks on the sequencing
  a_reset_float: assert property (
    @(posedge clock) !rst_q_n |=> !core_clock_oe && !reset_done_oe)
    else $error("outputs driven during reset");
  a_reset_idle: assert property (
    @(posedge clock) !rst_q_n |=> seq_idle && !reset_done)
    else $error("sequencer not idle in reset");
  a_done_delay: assert property (
    @(posedge clock) disable iff (!rst_q_n)
    $rose(reset_done) |-> done_cnt_r == '0 && $past(state_r == CCR_RUN))
    else $error("reset done before delay ran out");
  a_done_bound: assert property (
    @(posedge clock) disable iff (!rst_q_n)
    state_r == CCR_CAPTURE |-> ##[21:23] reset_done)
    else $error("reset done late");
  a_ratio_frozen: assert property (
    @(posedge clock) disable iff (!rst_q_n)
    state_r == CCR_RUN |=> $stable(core_ratio))
    else $error("ratio changed outside reset");
  a_ratio_decode: assert property (
    @(posedge clock) disable iff (!rst_q_n)
    state_r == CCR_CAPTURE |=> core_ratio ==
      ($past(strap_q) == STRAP_RSVD ? RATIO_RST :
       $past(strap_q) > STRAP_R8 ? {$past(strap_q), 1'b0} :
       {1'b0, $past(strap_q)} + RATIO_4)
      && ratio_reserved == ($past(strap_q) == STRAP_RSVD))
    else $error("strap decoded wrongly");
  a_burst_load: assert property (
    @(posedge clock) disable iff (!rst_q_n)
    state_r == CCR_RUN && sclk_rise |=> half_r == {core_ratio, 1'b0}
      && !core_clock)
    else $error("burst length not twice the ratio");
  a_clock_toggle: assert property (
    @(posedge clock) disable iff (!rst_q_n)
    state_r == CCR_RUN && !sclk_rise && half_r != HALF_ZERO
      |=> core_clock != $past(core_clock))
    else $error("core clock missed a half period");
  a_sync_release: assert property (
    @(posedge clock) $rose(rst_n) |-> !rst_q_n ##1 !rst_q_n)
    else $error("reset released without synchroniser");

  c_reach_run: cover property (@(posedge clock) $rose(reset_done));
  c_burst: cover property (@(posedge clock)
    state_r == CCR_RUN && sclk_rise);
  c_reserved: cover property (@(posedge clock) $rose(ratio_reserved));
  c_dram_up: cover property (@(posedge clock) $fell(seq_idle));
endmodule

/* File: dv/ccr_board.sv */
// board model: free-running system clock, reset_done looped to por
// assumes the bench clock; strap and reset come from the bench
`timescale 1ns/1ps
module ccr_board
#(
  parameter int HALF = 16
)
(
  input wire logic clock,
  input wire logic reset_done,
  input wire logic reset_done_oe,
  output logic sys_clock_pin,
  output logic dram_por_in_n
);
  int cnt = 0;
  initial sys_clock_pin = 1'b0;
  // period of 32 clocks outlasts the longest burst of 24 toggles
  always @(posedge clock)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      sys_clock_pin <= ~sys_clock_pin;
  end
  // direct loop back
  // a released pin sinks to its pull-down
  assign dram_por_in_n = reset_done_oe & reset_done;
endmodule

/* File: dv/ccr_top_bench.sv */
// self-checking bench for the core clock ratio and reset front end
// assumes ccr_top and the board model beside it
`timescale 1ns/1ps
module ccr_top_bench;
  import ccr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [STRAP_W-1:0] strap = STRAP_R4;
  logic sys_clk, por_n, cc, cc_oe, rd, rd_oe, idle, dinit, rsv;
  logic [RATIO_W-1:0] ratio;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int pulses = 0;
  // rows: strap, expected ratio, expected reserved flag
  logic [7:0] rows [8] = '{8'h08, 8'h2A, 8'h4C, 8'h6E,
                           8'h90, 8'hB4, 8'hD8, 8'hE9};

  ccr_top dut (.clock(clock), .rst_n(rst_n), .core_ratio_strap(strap),
    .sys_clock_pin(sys_clk), .dram_por_in_n(por_n), .core_clock(cc),
    .core_clock_oe(cc_oe), .reset_done(rd), .reset_done_oe(rd_oe),
    .seq_idle(idle), .dram_init(dinit), .core_ratio(ratio),
    .ratio_reserved(rsv));
  ccr_board board (.clock(clock), .reset_done(rd),
    .reset_done_oe(rd_oe), .sys_clock_pin(sys_clk),
    .dram_por_in_n(por_n));

  // 200 MHz clock
  initial
    forever #2.5 clock = ~clock;

  // core clock pulses, only counted
  always @(posedge cc)
    pulses++;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    if (got !== exp)
      failures++;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // strap moves only while reset is held
  task automatic do_reset(input logic [STRAP_W-1:0] s);
    @(posedge clock) rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    strap <= s;
    repeat (4) @(negedge clock);
    chk({cc_oe, rd_oe, rd, idle, ratio}, 8'h14);
    @(posedge clock) rst_n <= 1'b1;
  endtask

  // bounded wait for reset_done, then a check that the sequencer left idle
  task automatic wait_done();
    int i;
    for (i = 0; i < 80 && rd !== 1'b1; i++)
      @(negedge clock);
    // done must arrive, not before the count, within sync and state steps
    chk({6'h00, rd, 1'(i >= RST_DONE_CYC && i <= RST_DONE_CYC + 10)},
      8'h03);
    repeat (6) @(negedge clock);
    chk({rd, rd_oe, dinit, idle}, 8'h0E);
  endtask

  // one full burst lies between two system clock rises
  task automatic burst(input logic [3:0] n);
    @(posedge sys_clk);
    pulses = 0;
    @(posedge sys_clk);
    chk(8'(pulses), {4'h0, n});
    chk({cc_oe, 7'h00}, 8'h80);
  endtask

  // hang guard, a run needs under 2000 cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      failures++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (12) @(posedge clock);
    foreach (rows[k])
    begin
      do_reset(rows[k][7:5]);
      wait_done();
      chk({3'h0, ratio, rsv}, {3'h0, rows[k][4:0]});
      burst(rows[k][4:1]);
    end
    // strap moved outside reset must not alter the ratio
    strap <= STRAP_R12;
    repeat (10) @(negedge clock);
    chk({3'h0, ratio, rsv}, 8'h09);
    burst(RATIO_4);
    // reset in mid-run, then the largest ratio
    do_reset(STRAP_R12);
    wait_done();
    chk({3'h0, ratio, rsv}, 8'h18);
    burst(RATIO_12);
    wrap_up();
  end
endmodule
